// ### pkg/lia_defines.svh
// Shared constants of the lock-in I/Q demodulator
`ifndef LIA_DEFINES_SVH
`define LIA_DEFINES_SVH

// Converter sample width in bits
`define LIA_SAMPLE_W     12
// Reference value width, signed
`define LIA_REF_W        16
// Reference table index width, 16 steps per period
`define LIA_IDX_W        4
// Index distance of the 90 degree copy
`define LIA_QUAD_OFFSET  4'h4
// System clock period in ns
`define LIA_CLK_NS       50
// Reference update and sampling period in ns (400 kHz)
`define LIA_UPDATE_NS    2500
// Clock cycles per reference update
`define LIA_TICK_CYCLES  (`LIA_UPDATE_NS / `LIA_CLK_NS)
// Products per batch
`define LIA_BATCH_LEN    1024
// First stage decimation factor
`define LIA_DECIM        64
// Width of the final accumulators and results
`define LIA_ACC_W        38
// Index at reset, so the first update issues index zero, ladder code 8
`define LIA_IDX_RST      4'hF
// Ladder code at reset, mid scale
`define LIA_LADDER_RST   4'h8

`endif

// ### pkg/lia_pkg.sv
// Types and shared decode functions of the lock-in demodulator
`default_nettype none
`include "lia_defines.svh"
package lia_pkg;

    // Signed reference value
    typedef logic signed [`LIA_REF_W-1:0] lia_ref_t;

    // Reference and its 90 degree copy
    typedef struct packed {
        lia_ref_t inph;
        lia_ref_t quad;
    } lia_ref_pair_t;

    // Final in-phase and quadrature pair
    typedef struct packed {
        logic signed [`LIA_ACC_W-1:0] i;
        logic signed [`LIA_ACC_W-1:0] q;
    } lia_result_t;

    // Batch control states, one-hot
    typedef enum logic [2:0] {
        LIA_ST_ALIGN   = 3'h1,
        LIA_ST_COLLECT = 3'h2,
        LIA_ST_DUMP    = 3'h4
    } lia_state_t;

    // Fine sine value of one table step, 16-bit precision
    function automatic lia_ref_t lia_sine_val(
        input logic [`LIA_IDX_W-1:0] idx
    );
        lia_ref_t mag;
        case (idx[2:0])
            3'h0:       mag = 16'h0000;
            3'h1, 3'h7: mag = 16'h30FC;
            3'h2, 3'h6: mag = 16'h5A82;
            3'h3, 3'h5: mag = 16'h7642;
            default:    mag = 16'h7FFF;
        endcase
        return idx[3] ? -mag : mag;
    endfunction

    // Sixteen level ladder code of one table step
    function automatic logic [`LIA_IDX_W-1:0] lia_ladder_code(
        input logic [`LIA_IDX_W-1:0] idx
    );
        case (idx)
            4'h0, 4'h8: return 4'h8;
            4'h1, 4'h7: return 4'hA;
            4'h2, 4'h6: return 4'hD;
            4'h3, 4'h5: return 4'hE;
            4'h4:       return 4'hF;
            4'h9, 4'hF: return 4'h5;
            4'hA, 4'hE: return 4'h2;
            4'hB, 4'hD: return 4'h1;
            default:    return 4'h0;
        endcase
    endfunction

    // External ladder-style code to signed value, (code-8)*2048
    function automatic lia_ref_t lia_ext_to_ref(
        input logic [`LIA_IDX_W-1:0] code
    );
        return {~code[3], ~code[3], code[2:0], 11'h000};
    endfunction

endpackage

`default_nettype wire

// ### src/lia_ref_gen.sv
// Reference time base, sine table and 90 degree copy
`timescale 1ns/100ps
`default_nettype none
`include "lia_defines.svh"

module lia_ref_gen #(
    parameter int TICK_CYCLES = `LIA_TICK_CYCLES
) (
    input  wire logic                  sys_clk_in,
    input  wire logic                  rst_b_in,
    input  wire logic                  clk_en_in,
    input  wire logic                  ext_sel_in,
    input  wire logic [`LIA_IDX_W-1:0] ext_code_in,
    output logic                       tick_out,
    output logic [`LIA_IDX_W-1:0]      index_out,
    output logic [`LIA_IDX_W-1:0]      ladder_out,
    output lia_pkg::lia_ref_pair_t     ref_pair_out
);
    import lia_pkg::*;

    localparam int CW     = $clog2(TICK_CYCLES);
    localparam int TICK_N = TICK_CYCLES;

    logic [CW-1:0]                  div_q, div_d;   // Update divider
    logic                           tick_q, tick_d; // Update pulse
    logic [`LIA_IDX_W-1:0]          idx_q, idx_d;   // Table index
    logic [`LIA_IDX_W-1:0]          lad_q, lad_d;   // Ladder code
    lia_ref_pair_t                  pair_q, pair_d; // Reference pair
    logic [3:0][`LIA_IDX_W-1:0]     hist_q, hist_d; // External history

    default clocking cb @(posedge sys_clk_in iff clk_en_in);
    endclocking
    default disable iff (!rst_b_in);

    ////////////////////////////////////////////////////////////////////
    // Next state of divider, index and reference
    always_comb begin
        div_d  = div_q;
        tick_d = 1'b0;
        idx_d  = idx_q;
        lad_d  = lad_q;
        pair_d = pair_q;
        hist_d = hist_q;
        if (div_q == CW'(TICK_CYCLES - 1)) begin
            // Period end: issue next code
            div_d  = '0;
            tick_d = 1'b1;
            idx_d  = idx_q + 4'h1;
            lad_d  = lia_ladder_code(idx_d);
            hist_d = {hist_q[2:0], ext_code_in};
            if (ext_sel_in) begin
                // Sampled outside reference, quad lags 4 steps, negated
                pair_d.inph = lia_ext_to_ref(ext_code_in);
                pair_d.quad = -lia_ext_to_ref(hist_q[3]);
            end else begin
                // Internal fine table
                pair_d.inph = lia_sine_val(idx_d);
                pair_d.quad = lia_sine_val(idx_d + `LIA_QUAD_OFFSET);
            end
        end else begin
            // Count within the period
            div_d = div_q + CW'(1);
        end
    end

    // State registers, frozen while the enable is low
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            div_q  <= '0;
            tick_q <= 1'b0;
            idx_q  <= `LIA_IDX_RST;
            lad_q  <= `LIA_LADDER_RST;
            pair_q <= '0;
            hist_q <= '0;
        end else if (clk_en_in) begin
            div_q  <= div_d;
            tick_q <= tick_d;
            idx_q  <= idx_d;
            lad_q  <= lad_d;
            pair_q <= pair_d;
            hist_q <= hist_d;
        end
    end

    assign tick_out     = tick_q;
    assign index_out    = idx_q;
    assign ladder_out   = lad_q;
    assign ref_pair_out = pair_q;

    ////////////////////////////////////////////////////////////////////
    // Checks on the time base and table
    tick_period_a:
    assert property (tick_out |-> ##TICK_N tick_out)
        else $error("Reference update period wrong");

    // Pulse only at divider wrap, then quiet; periods of 8 or more
    tick_gap_a:
    assert property (tick_out |-> div_q == '0 ##1 (!tick_out) [*7])
        else $error("Reference update repeated too soon");

    index_wrap_a:
    assert property (tick_out && index_out == 4'hF
                     |-> ##TICK_N (tick_out && index_out == 4'h0))
        else $error("Index did not wrap to zero");

    quad_table_a:
    assert property ($rose(tick_out) && !$past(ext_sel_in)
        |-> ref_pair_out.inph == lia_sine_val(index_out)
            && ref_pair_out.quad == lia_sine_val(index_out + 4'h4))
        else $error("Quadrature value not four steps ahead");

    ladder_code_a:
    assert property (tick_out |-> ##1 ladder_out == lia_ladder_code(index_out))
        else $error("Ladder code does not match index");

endmodule // lia_ref_gen

`default_nettype wire

// ### src/lia_demod.sv
// Lock-in I/Q demodulator datapath, top level
`timescale 1ns/100ps
`default_nettype none
`include "lia_defines.svh"

////////////////////////////////////////////////////////////////////////
// Function
// - Take 12-bit samples, up to 400 kHz
// - Make a 90 degree shifted reference
// - Multiply sample by reference and quadrature
// - Low-pass filter both products into results
// - Drive ladder with 16-level sine codes
// - New code every 2.5 us (400 kHz), sine 25 kHz
// - Internal table or sampled outside reference
// - Timings are whole multiples of clock
// - Fine reference precise to -90 dB
// - Trigger and code share one time base
// - Batches of 1024; ignore samples between
// - Each batch starts at first reference code
// - Decimate by 64 before final stage
////////////////////////////////////////////////////////////////////////

module lia_demod #(
    parameter int TICK_CYCLES = `LIA_TICK_CYCLES,
    parameter int BATCH_LEN   = `LIA_BATCH_LEN,
    parameter int DECIM       = `LIA_DECIM
) (
    input  wire logic                     sys_clk_in,
    input  wire logic                     rst_b_in,
    input  wire logic                     clk_en_in,
    input  wire logic [`LIA_SAMPLE_W-1:0] adc_sample_in,
    input  wire logic                     adc_valid_in,
    input  wire logic                     ext_ref_sel_in,
    input  wire logic [`LIA_IDX_W-1:0]    ext_ref_code_in,
    output logic                          adc_trigger_out,
    output logic [`LIA_IDX_W-1:0]         ladder_code_out,
    output logic                          batch_busy_out,
    output lia_pkg::lia_result_t          result_out,
    output logic                          result_valid_out
);
    import lia_pkg::*;

    // Datapath widths
    localparam int PROD_W = `LIA_SAMPLE_W + `LIA_REF_W;
    localparam int DW     = $clog2(DECIM);
    localparam int ACC1_W = PROD_W + DW;
    localparam int CNT_W  = $clog2(BATCH_LEN);

    lia_state_t                       state_q, state_d; // Batch control
    logic [CNT_W-1:0]                 cnt_q, cnt_d;     // Products taken
    lia_result_t                      result_q, result_d;
    logic                             valid_q, valid_d;

    logic                             ref_tick;   // Update pulse
    logic [`LIA_IDX_W-1:0]            ref_idx;    // Current step
    lia_ref_pair_t                    ref_pair;   // Reference pair
    lia_ref_t                         ref_v [2];  // Per channel ref
    logic signed [`LIA_SAMPLE_W-1:0]  samp_s;     // Centred sample
    logic                             accept;     // Product taken
    logic                             decim_end;  // Stage one dump
    logic                             last_smp;   // Batch complete
    logic signed [`LIA_ACC_W-1:0]     lpf2_v [2]; // Stage two sums

    default clocking cb @(posedge sys_clk_in iff clk_en_in);
    endclocking
    default disable iff (!rst_b_in);

    ////////////////////////////////////////////////////////////////////
    // Reference generator, one time base for ladder and trigger
    lia_ref_gen #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_ref_gen (
        .sys_clk_in   (sys_clk_in),
        .rst_b_in     (rst_b_in),
        .clk_en_in    (clk_en_in),
        .ext_sel_in   (ext_ref_sel_in),
        .ext_code_in  (ext_ref_code_in),
        .tick_out     (ref_tick),
        .index_out    (ref_idx),
        .ladder_out   (ladder_code_out),
        .ref_pair_out (ref_pair)
    );

    // Converter start pulse is the code update pulse itself
    assign adc_trigger_out = ref_tick;

    // Channel references: 0 in-phase, 1 quadrature
    assign ref_v[0] = ref_pair.inph;
    assign ref_v[1] = ref_pair.quad;

    ////////////////////////////////////////////////////////////////////
    // Sample handling

    // Offset binary to two's complement around mid scale
    assign samp_s = {~adc_sample_in[`LIA_SAMPLE_W-1],
                     adc_sample_in[`LIA_SAMPLE_W-2:0]};

    // Samples only count while a batch is collecting
    assign accept    = adc_valid_in && (state_q == LIA_ST_COLLECT);
    // Last product of each decimation group
    assign decim_end = accept && (cnt_q[DW-1:0] == {DW{1'b1}});
    // Last product of the batch
    assign last_smp  = accept && (cnt_q == CNT_W'(BATCH_LEN - 1));

    ////////////////////////////////////////////////////////////////////
    // Batch control, next state
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        case (state_q)
            LIA_ST_ALIGN: begin
                // Wait for the first code of a period
                cnt_d = '0;
                if (ref_tick && ref_idx == '0) begin
                    state_d = LIA_ST_COLLECT;
                end
            end
            LIA_ST_COLLECT: begin
                // Count products until the batch is full
                if (accept) begin
                    cnt_d = cnt_q + CNT_W'(1);
                end
                if (last_smp) begin
                    state_d = LIA_ST_DUMP;
                end
            end
            LIA_ST_DUMP: begin
                // One cycle to publish the result
                state_d = LIA_ST_ALIGN;
            end
            default: begin
                // Illegal code, recover
                state_d = LIA_ST_ALIGN;
                cnt_d   = '0;
            end
        endcase
    end

    // Batch control registers
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_q <= LIA_ST_ALIGN;
            cnt_q   <= '0;
        end else if (clk_en_in) begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    // Busy whenever samples would be thrown away
    assign batch_busy_out = (state_q != LIA_ST_COLLECT);

    ////////////////////////////////////////////////////////////////////
    // Mixer and two filter stages, one copy per channel
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        logic signed [PROD_W-1:0]     prod;           // Mixer output
        logic signed [ACC1_W-1:0]     lpf1_q, lpf1_d; // Boxcar sum
        logic signed [`LIA_ACC_W-1:0] lpf2_q, lpf2_d; // Final sum

        // Multiply, accumulate and dump
        always_comb begin
            prod   = samp_s * ref_v[ch];
            lpf1_d = lpf1_q;
            lpf2_d = lpf2_q;
            if (accept) begin
                if (decim_end) begin
                    // Hand a decimated value to the final stage
                    lpf1_d = '0;
                    lpf2_d = lpf2_q
                           + `LIA_ACC_W'(lpf1_q + ACC1_W'(prod));
                end else begin
                    // Boxcar low-pass over one group
                    lpf1_d = lpf1_q + ACC1_W'(prod);
                end
            end else if (state_q == LIA_ST_DUMP) begin
                // Final sum taken; start the next batch clean
                lpf2_d = '0;
            end
        end

        // Filter registers
        always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
                lpf1_q <= '0;
                lpf2_q <= '0;
            end else if (clk_en_in) begin
                lpf1_q <= lpf1_d;
                lpf2_q <= lpf2_d;
            end
        end

        assign lpf2_v[ch] = lpf2_q;
    end

    ////////////////////////////////////////////////////////////////////
    // Result register and valid pulse
    always_comb begin
        result_d = result_q;
        valid_d  = 1'b0;
        if (state_q == LIA_ST_DUMP) begin
            // Publish the final pair for one cycle of valid
            result_d.i = lpf2_v[0];
            result_d.q = lpf2_v[1];
            valid_d    = 1'b1;
        end
    end

    // Result registers
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            result_q <= '0;
            valid_q  <= 1'b0;
        end else if (clk_en_in) begin
            result_q <= result_d;
            valid_q  <= valid_d;
        end
    end

    assign result_out       = result_q;
    assign result_valid_out = valid_q;

    ////////////////////////////////////////////////////////////////////
    // Checks on batching, mixing and results
    align_start_a:
    assert property (state_q == LIA_ST_ALIGN && ref_tick && ref_idx == '0
                     |=> state_q == LIA_ST_COLLECT && cnt_q == '0)
        else $error("Batch did not start on first code");

    batch_end_a:
    assert property (last_smp
        |=> state_q == LIA_ST_DUMP ##1 state_q == LIA_ST_ALIGN)
        else $error("Batch did not close after last product");

    ignore_smp_a:
    assert property (state_q == LIA_ST_ALIGN && adc_valid_in
        |=> $stable(g_chan[0].lpf1_q) && $stable(g_chan[1].lpf1_q))
        else $error("Sample taken between batches");

    decim_dump_a:
    assert property (decim_end
        |=> g_chan[0].lpf1_q == '0 && g_chan[1].lpf1_q == '0)
        else $error("First stage not dumped after group");

    quad_mix_a:
    assert property (accept && !decim_end
        |=> g_chan[1].lpf1_q == $past(g_chan[1].lpf1_q)
            + ACC1_W'($past(samp_s)) * ACC1_W'($past(ref_v[1])))
        else $error("Quadrature product not accumulated");

    final_pair_a:
    assert property (state_q == LIA_ST_DUMP
        |=> result_out.i == $past(lpf2_v[0])
            && result_out.q == $past(lpf2_v[1]) && g_chan[0].lpf2_q == '0)
        else $error("Result pair not taken from final stage");

    valid_pulse_a:
    assert property (state_q == LIA_ST_DUMP
        |=> result_valid_out ##1 !result_valid_out)
        else $error("Result valid not a single cycle");

    trig_code_a:
    assert property (adc_trigger_out
        |-> ##1 ladder_code_out == lia_ladder_code(ref_idx))
        else $error("Trigger and code update out of step");

endmodule // lia_demod

`default_nettype wire

// ### test/lia_link_model.sv
// Converter and ladder loopback partner for the demodulator bench
`timescale 1ns/100ps
`default_nettype none
`include "lia_defines.svh"

module lia_link_model #(
    parameter int GAIN = 64  // Sample steps per ladder step
) (
    input  wire logic                     sys_clk_in,
    input  wire logic                     rst_b_in,
    input  wire logic                     clk_en_in,
    input  wire logic                     trigger_in,
    input  wire logic [`LIA_IDX_W-1:0]    ladder_in,
    input  wire logic [3:0]               delay_in,
    output logic      [`LIA_SAMPLE_W-1:0] sample_out,
    output logic                          valid_out
);
    logic       armed_q;  // Conversion in flight
    logic [3:0] wait_q;   // Cycles left to conversion end

    // Offset binary level seen through ladder and bridge
    function automatic logic [`LIA_SAMPLE_W-1:0] level(
        input logic [`LIA_IDX_W-1:0] code
    );
        return 12'(2048 + (int'(code) - 8) * GAIN);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // One conversion per trigger, done delay_in cycles later
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            armed_q    <= 1'b0;
            wait_q     <= 4'h0;
            valid_out  <= 1'b0;
            sample_out <= 12'h0A5;
        end else if (clk_en_in) begin
            valid_out  <= 1'b0;
            // Released data line toggles, stale data shows every other cycle
            sample_out <= ~sample_out;
            if (trigger_in) begin
                armed_q <= 1'b1;
                wait_q  <= delay_in;
            end else if (armed_q && wait_q > 4'h1) begin
                wait_q <= wait_q - 4'h1;
            end else if (armed_q) begin
                // Result lands before the next trigger
                armed_q    <= 1'b0;
                valid_out  <= 1'b1;
                sample_out <= level(ladder_in);
            end
        end
    end
endmodule // lia_link_model
`default_nettype wire

// ### test/tb_top.sv
// Self-checking bench of the lock-in demodulator top level
`timescale 1ns/100ps
`default_nettype none
`include "lia_defines.svh"

module tb_top;
    import lia_pkg::*;
    localparam int TICK  = 8;     // Shortened update period
    localparam int BATCH = 64;    // Shortened batch
    localparam int DECIM = 16;    // Shortened decimation
    localparam int GAIN  = 64;    // Loopback gain
    localparam int LIMIT = 10000; // Hang ceiling in cycles

    logic                     sys_clk  = 1'b0;
    logic                     rst_b    = 1'b0;
    logic                     clk_en   = 1'b1;
    logic                     ext_sel  = 1'b0;
    logic [3:0]               ext_code = 4'h8;
    logic [3:0]               delay    = 4'h1;
    logic [`LIA_SAMPLE_W-1:0] sample;
    logic                     valid;
    logic                     trigger;
    logic [3:0]               ladder;
    logic                     busy;
    lia_result_t              result;
    logic                     res_valid;
    int                       n_fail    = 0;
    int                       tests_run = 0;
    int                       cycles    = 0;
    int code_tab[16] = '{8, 10, 13, 14, 15, 14, 13, 10,
                         8, 5, 2, 1, 0, 1, 2, 5};
    int sin_mag[5]   = '{0, 12540, 23170, 30274, 32767};

    lia_demod #(.TICK_CYCLES(TICK), .BATCH_LEN(BATCH), .DECIM(DECIM))
    u_dut (
        .sys_clk_in       (sys_clk),
        .rst_b_in         (rst_b),
        .clk_en_in        (clk_en),
        .adc_sample_in    (sample),
        .adc_valid_in     (valid),
        .ext_ref_sel_in   (ext_sel),
        .ext_ref_code_in  (ext_code),
        .adc_trigger_out  (trigger),
        .ladder_code_out  (ladder),
        .batch_busy_out   (busy),
        .result_out       (result),
        .result_valid_out (res_valid)
    );

    lia_link_model #(.GAIN(GAIN)) u_link (
        .sys_clk_in (sys_clk),
        .rst_b_in   (rst_b),
        .clk_en_in  (clk_en),
        .trigger_in (trigger),
        .ladder_in  (ladder),
        .delay_in   (delay),
        .sample_out (sample),
        .valid_out  (valid)
    );

    ////////////////////////////////////////////////////////////////////
    // Clock, outside reference loopback and hang guard
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end

    // Outside reference follows the ladder, one update behind
    always @(posedge sys_clk) ext_code <= #2 ladder;

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_fail++;
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Shared helpers
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask

    task automatic check(input logic [75:0] got, input logic [75:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic longint sin_v(input int i);
        int j;
        j = i % 8;
        sin_v = (j <= 4) ? sin_mag[j] : sin_mag[8 - j];
        if ((i % 16) >= 8) sin_v = -sin_v;
    endfunction

    // Pair expected from a loopback of the ladder codes
    function automatic logic [75:0] expect_pair(input bit ext);
        longint si, sq, dev;
        si = 0;
        sq = 0;
        for (int i = 0; i < 16; i++) begin
            dev = longint'((code_tab[i] - 8) * GAIN);
            if (ext) begin
                si += dev * (code_tab[(i + 15) % 16] - 8) * 2048;
                sq -= dev * (code_tab[(i + 11) % 16] - 8) * 2048;
            end else begin
                si += dev * sin_v(i);
                sq += dev * sin_v(i + 4);
            end
        end
        return {38'(si * (BATCH / 16)), 38'(sq * (BATCH / 16))};
    endfunction

    // Wait for the next result pulse, bounded
    task automatic wait_result();
        int n;
        n = 0;
        while (res_valid !== 1'b1 && n < 1200) begin
            step(1);
            n++;
        end
        check(76'(n < 1200), 76'(1));
    endtask

    // One batch: result, busy, pulse width and hold
    task automatic run_batch(input bit ext);
        logic [75:0] held;
        wait_result();
        check(result, expect_pair(ext));
        check(76'(busy), 76'(1));
        held = result;
        step(1);
        check(76'(res_valid), 76'(0));
        step(4);
        check(result, held);
    endtask

    ////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset();
        check(76'(ladder), 76'(`LIA_LADDER_RST));
        check(76'({busy, res_valid, trigger}), 76'(4));
        check(result, 76'(0));
    endtask

    task automatic t_ref_seq();
        int gap;
        gap = 0;
        for (int k = 0; k <= 16; k++) begin
            while (trigger !== 1'b1 && gap < 2 * TICK) begin
                step(1);
                gap++;
            end
            if (k > 0) check(76'(gap), 76'(TICK));
            step(1);
            check(76'(ladder), 76'(code_tab[k % 16]));
            if (k == 0) check(76'(busy), 76'(0));
            gap = 1;
        end
    endtask

    task automatic t_first_batch();
        run_batch(1'b0);
    endtask

    task automatic t_rebatch();
        run_batch(1'b0);
    endtask

    task automatic t_slow_pause();
        delay = 4'h6;
        step(100);
        clk_en = 1'b0;
        step(30);
        clk_en = 1'b1;
        run_batch(1'b0);
    endtask

    task automatic t_ext_ref();
        ext_sel = 1'b1;
        delay   = 4'h1;
        wait_result();
        step(1);
        run_batch(1'b1);
    endtask

    ////////////////////////////////////////////////////////////////////
    // Closing report
    task automatic conclude();
        $display("checks=%0d mismatches=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        step(16);
        t_reset();
        rst_b = 1'b1;
        t_ref_seq();
        t_first_batch();
        t_rebatch();
        t_slow_pause();
        t_ext_ref();
        conclude();
    end
endmodule // tb_top
`default_nettype wire
